//--- design/wdmc_defines.svh
// Offsets, field positions, widths and reset values of the watchdog control block
`ifndef WDMC_DEFINES_SVH
`define WDMC_DEFINES_SVH

`define WDMC_ADDR_W        8
`define WDMC_OFS_CONTROL_A_REG     8'h00
`define WDMC_OFS_CONFIG    8'h04
`define WDMC_OFS_EARLY_WARN_CTRL_REG    8'h08
`define WDMC_OFS_INTMASK   8'h0c
`define WDMC_OFS_INTFLAG   8'h10
`define WDMC_OFS_MODE      8'h14

`define WDMC_CONTROL_A_REG_EN      1
`define WDMC_CONTROL_A_REG_WEN     2
`define WDMC_CONTROL_A_REG_LOCK    7

`define WDMC_FIELD_W       4
`define WDMC_CFG_PER_LSB   0
`define WDMC_CFG_WIN_LSB   4
`define WDMC_EW_OFS_LSB    0

`define WDMC_FLAG_W        3
`define WDMC_FLAG_EW       0
`define WDMC_FLAG_PROT     1
`define WDMC_FLAG_LOCK     2

`define WDMC_MODE_RUN_BIT  4
`define WDMC_MODE_W        3

`define WDMC_FLAG_RST      3'h0
`define WDMC_FIELD_RST     4'h0

`endif

//--- design/wdmc_pkg.sv
// Types shared by the watchdog control block
`include "wdmc_defines.svh"

package wdmc_pkg;

  typedef struct packed {
    logic lock_enabled;
    logic wen;
    logic enable;
  } wdmc_ctrl_t;

  typedef struct packed {
    logic [`WDMC_FIELD_W-1:0] window;
    logic [`WDMC_FIELD_W-1:0] timeout_period_sel;
  } wdmc_cfg_t;

  typedef struct packed {
    wdmc_ctrl_t               ctrl;
    wdmc_cfg_t                cfg;
    logic [`WDMC_FIELD_W-1:0] early_warn_offset;
  } wdmc_user_row_t;

  typedef enum logic [`WDMC_MODE_W-1:0] {
    WDMC_STOPPED,
    WDMC_NORMAL,
    WDMC_NORMAL_EW,
    WDMC_WINDOW,
    WDMC_WINDOW_EW
  } wdmc_mode_t;

  typedef enum logic {
    WDMC_LD_WAIT,
    WDMC_LD_DONE
  } wdmc_ld_state_t;

endpackage

//--- design/wdmc_row_loader.sv
// Waits for the nonvolatile user row after power-on and issues one load pulse
`timescale 1ns/1ps

module wdmc_row_loader
  import wdmc_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic user_row_valid,
  output logic      load,
  output logic      loaded
);

  wdmc_ld_state_t state;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= WDMC_LD_WAIT;
    end else if (state == WDMC_LD_WAIT && user_row_valid) begin
      state <= WDMC_LD_DONE;
    end
  end

  // Row is sampled by the clocked load, never by the reset itself
  assign load   = (state == WDMC_LD_WAIT) && user_row_valid;
  assign loaded = (state == WDMC_LD_DONE);

endmodule

//--- design/wdmc_mode_decode.sv
// Registered operating mode decode of the watchdog
`timescale 1ns/1ps

module wdmc_mode_decode
  import wdmc_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  input  wire logic wen,
  input  wire logic ew_int_en,
  output wdmc_mode_t mode,
  output logic       counter_run
);

  function automatic wdmc_mode_t decode(input logic en, input logic w, input logic ie);
    wdmc_mode_t m;
    m = WDMC_STOPPED;
    if (en) begin
      if (w) begin
        m = ie ? WDMC_WINDOW_EW : WDMC_WINDOW;
      end else begin
        m = ie ? WDMC_NORMAL_EW : WDMC_NORMAL;
      end
    end
    return m;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode        <= WDMC_STOPPED;
      counter_run <= 1'b0;
    end else begin
      mode        <= decode(enable, wen, ew_int_en);
      counter_run <= enable;
    end
  end

endmodule

//--- design/wdmc_ctrl.sv
// Watchdog mode, enable protection and user-row load control with AHB-Lite registers
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "wdmc_defines.svh"

module wdmc_ctrl
  import wdmc_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic                     user_row_valid,
  input  wire wdmc_user_row_t           user_row,
  input  wire logic                     early_warn_event,
  input  wire logic                     timeout_event,
  output logic                          counter_run,
  output wdmc_mode_t                    mode,
  output logic      [`WDMC_FIELD_W-1:0] timeout_period_sel,
  output logic      [`WDMC_FIELD_W-1:0] window_period,
  output logic      [`WDMC_FIELD_W-1:0] early_warn_offset,
  output logic                          wdt_reset,
  output logic                          irq
);

  function automatic logic hit(input logic [`WDMC_ADDR_W-1:0] a, input logic [`WDMC_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  wdmc_ctrl_t                 control_a_reg;
  wdmc_cfg_t                  config_reg;
  logic [`WDMC_FIELD_W-1:0]   early_warn_ctrl_reg;
  logic [`WDMC_FLAG_W-1:0]    int_mask;
  logic [`WDMC_FLAG_W-1:0]    int_flag;
  logic                       load;
  logic                       loaded;
  logic                       dvalid;
  logic                       dwrite;
  logic [`WDMC_ADDR_W-1:0]    daddr;
  logic                       rd_done;
  logic                       addr_take;
  logic                       wr_fire;
  logic                       rd_fire;
  logic                       wr_ctrl;
  logic                       wr_cfg;
  logic                       wr_ew;
  logic                       prot_refused;
  logic                       lock_refused;
  logic [`WDMC_FLAG_W-1:0]    flag_set;
  logic [31:0]                next_rdata;

  wdmc_row_loader u_loader (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .user_row_valid (user_row_valid),
    .load           (load),
    .loaded         (loaded)
  );

  wdmc_mode_decode u_decode (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .enable      (control_a_reg.enable),
    .wen         (control_a_reg.wen),
    .ew_int_en   (int_mask[`WDMC_FLAG_EW]),
    .mode        (mode),
    .counter_run (counter_run)
  );

  // Bus data phase tracking
  // Data phases stall until the user row is in, so no write races the load
  assign hreadyout = !dvalid || (loaded && (dwrite || rd_done));
  assign hresp     = 1'b0;
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_fire   = dvalid && dwrite && loaded;
  assign rd_fire   = dvalid && !dwrite && loaded && !rd_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dvalid  <= 1'b0;
      dwrite  <= 1'b0;
      daddr   <= '0;
      rd_done <= 1'b0;
    end else begin
      if (hready) begin
        dvalid  <= addr_take;
        dwrite  <= hwrite;
        daddr   <= haddr[`WDMC_ADDR_W-1:0];
        rd_done <= 1'b0;
      end else if (rd_fire) begin
        rd_done <= 1'b1;
      end
    end
  end

  assign wr_ctrl = wr_fire && hit(daddr, `WDMC_OFS_CONTROL_A_REG);
  assign wr_cfg  = wr_fire && hit(daddr, `WDMC_OFS_CONFIG);
  assign wr_ew   = wr_fire && hit(daddr, `WDMC_OFS_EARLY_WARN_CTRL_REG);

  // Control A: enable and protected bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_a_reg <= '0;
    end else if (load) begin
      control_a_reg <= user_row.ctrl;
    end else if (wr_ctrl) begin
      if (!control_a_reg.enable) begin
        // protected bits ride with enable set
        control_a_reg.wen          <= hwdata[`WDMC_CONTROL_A_REG_WEN];
        control_a_reg.lock_enabled <= hwdata[`WDMC_CONTROL_A_REG_LOCK];
        control_a_reg.enable       <= hwdata[`WDMC_CONTROL_A_REG_EN];
      end else if (!control_a_reg.lock_enabled) begin
        control_a_reg.enable       <= hwdata[`WDMC_CONTROL_A_REG_EN];
      end
    end
  end

  // Configuration and early-warning offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg          <= '0;
      early_warn_ctrl_reg <= `WDMC_FIELD_RST;
    end else if (load) begin
      // user row sets periods and offset
      config_reg          <= user_row.cfg;
      early_warn_ctrl_reg <= user_row.early_warn_offset;
    end else if (!control_a_reg.enable) begin
      if (wr_cfg) begin
        config_reg.timeout_period_sel <= hwdata[`WDMC_CFG_PER_LSB +: `WDMC_FIELD_W];
        config_reg.window             <= hwdata[`WDMC_CFG_WIN_LSB +: `WDMC_FIELD_W];
      end
      if (wr_ew) begin
        early_warn_ctrl_reg <= hwdata[`WDMC_EW_OFS_LSB +: `WDMC_FIELD_W];
      end
    end
  end

  assign timeout_period_sel = config_reg.timeout_period_sel;
  assign window_period      = config_reg.window;
  assign early_warn_offset  = early_warn_ctrl_reg;

  // Refused writes are reported, not silently lost
  assign prot_refused = control_a_reg.enable && (wr_cfg || wr_ew ||
                        (wr_ctrl && (hwdata[`WDMC_CONTROL_A_REG_WEN] != control_a_reg.wen ||
                                     hwdata[`WDMC_CONTROL_A_REG_LOCK] != control_a_reg.lock_enabled)));
  assign lock_refused = wr_ctrl && control_a_reg.enable && control_a_reg.lock_enabled &&
                        !hwdata[`WDMC_CONTROL_A_REG_EN];

  always_comb begin
    flag_set                  = '0;
    flag_set[`WDMC_FLAG_EW]   = early_warn_event && control_a_reg.enable;
    flag_set[`WDMC_FLAG_PROT] = prot_refused;
    flag_set[`WDMC_FLAG_LOCK] = lock_refused;
  end

  // Interrupt mask and sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask <= `WDMC_FLAG_RST;
    end else if (wr_fire && hit(daddr, `WDMC_OFS_INTMASK)) begin
      int_mask <= hwdata[`WDMC_FLAG_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_flag <= `WDMC_FLAG_RST;
    end else if (wr_fire && hit(daddr, `WDMC_OFS_INTFLAG)) begin
      int_flag <= (int_flag & ~hwdata[`WDMC_FLAG_W-1:0]) | flag_set;
    end else begin
      int_flag <= int_flag | flag_set;
    end
  end

  assign irq = |(int_flag & int_mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= timeout_event && control_a_reg.enable;
    end
  end

  // Read path; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    if (hit(daddr, `WDMC_OFS_CONTROL_A_REG)) begin
      next_rdata[`WDMC_CONTROL_A_REG_EN]   = control_a_reg.enable;
      next_rdata[`WDMC_CONTROL_A_REG_WEN]  = control_a_reg.wen;
      next_rdata[`WDMC_CONTROL_A_REG_LOCK] = control_a_reg.lock_enabled;
    end else if (hit(daddr, `WDMC_OFS_CONFIG)) begin
      next_rdata[`WDMC_CFG_PER_LSB +: `WDMC_FIELD_W] = config_reg.timeout_period_sel;
      next_rdata[`WDMC_CFG_WIN_LSB +: `WDMC_FIELD_W] = config_reg.window;
    end else if (hit(daddr, `WDMC_OFS_EARLY_WARN_CTRL_REG)) begin
      next_rdata[`WDMC_EW_OFS_LSB +: `WDMC_FIELD_W] = early_warn_ctrl_reg;
    end else if (hit(daddr, `WDMC_OFS_INTMASK)) begin
      next_rdata[`WDMC_FLAG_W-1:0] = int_mask;
    end else if (hit(daddr, `WDMC_OFS_INTFLAG)) begin
      next_rdata[`WDMC_FLAG_W-1:0] = int_flag;
    end else if (hit(daddr, `WDMC_OFS_MODE)) begin
      next_rdata[`WDMC_MODE_W-1:0]    = mode;
      next_rdata[`WDMC_MODE_RUN_BIT] = counter_run;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_fire) begin
      hrdata <= next_rdata;
    end
  end

  // Checks

  a_mode_stopped: assert property (@(posedge hclk) disable iff (!hresetn)
    !control_a_reg.enable |=> mode == WDMC_STOPPED)
    else $error("mode not stopped while disabled");

  a_mode_window_ew: assert property (@(posedge hclk) disable iff (!hresetn)
    (control_a_reg.enable && control_a_reg.wen && int_mask[`WDMC_FLAG_EW]) |=> mode == WDMC_WINDOW_EW)
    else $error("window early-warning mode not decoded");

  a_cfg_protected: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_cfg && control_a_reg.enable && !load) |=> $stable(config_reg) ##0 int_flag[`WDMC_FLAG_PROT])
    else $error("configuration written while enabled");

  a_enable_applies: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && !control_a_reg.enable && hwdata[`WDMC_CONTROL_A_REG_EN])
      |=> control_a_reg.enable && control_a_reg.wen == $past(hwdata[`WDMC_CONTROL_A_REG_WEN]))
    else $error("protected bits not applied with enable");

  a_clear_no_apply: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && control_a_reg.enable && !hwdata[`WDMC_CONTROL_A_REG_EN]) |=> $stable(control_a_reg.wen))
    else $error("protected bit changed on disabling write");

  a_period_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (counter_run && $past(control_a_reg.enable) && !$past(load)) |-> $stable(timeout_period_sel))
    else $error("timeout period changed while running");

  a_row_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
    load |=> control_a_reg == $past(user_row.ctrl) && early_warn_offset == $past(user_row.early_warn_offset))
    else $error("user row not loaded");

  a_enable_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && !control_a_reg.lock_enabled && !hwdata[`WDMC_CONTROL_A_REG_EN]) |=> !control_a_reg.enable ##1 !counter_run)
    else $error("enable clear not honoured");

  a_lock_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (control_a_reg.enable && control_a_reg.lock_enabled && !load) |=> control_a_reg.enable)
    else $error("locked watchdog was disabled");

  a_stop_silent: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(int_flag[`WDMC_FLAG_EW]) || wdt_reset |-> $past(control_a_reg.enable))
    else $error("warning or reset while stopped");

  a_ew_protected: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ew && control_a_reg.enable) |=> $stable(early_warn_ctrl_reg) ##0 int_flag[`WDMC_FLAG_PROT])
    else $error("early-warning offset written while enabled");

  a_lock_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_refused |=> control_a_reg.enable && int_flag[`WDMC_FLAG_LOCK])
    else $error("refused disable not flagged");

  a_warn_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_set[`WDMC_FLAG_EW] |=> int_flag[`WDMC_FLAG_EW])
    else $error("early-warning flag lost to a clear");

  a_reset_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout_event && control_a_reg.enable) |=> wdt_reset)
    else $error("timeout while running gave no reset");

  a_mode_normal: assert property (@(posedge hclk) disable iff (!hresetn)
    (control_a_reg.enable && !control_a_reg.wen)
      |=> mode == ($past(int_mask[`WDMC_FLAG_EW]) ? WDMC_NORMAL_EW : WDMC_NORMAL))
    else $error("normal mode not decoded");

  a_mode_window: assert property (@(posedge hclk) disable iff (!hresetn)
    (control_a_reg.enable && control_a_reg.wen && !int_mask[`WDMC_FLAG_EW]) |=> mode == WDMC_WINDOW)
    else $error("window mode not decoded");

  a_cfg_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
    load |=> config_reg == $past(user_row.cfg))
    else $error("user row periods not loaded");

endmodule

//--- sim/wdmc_ctrl_test.sv
// Self-checking bench of the watchdog control block against a register model
`timescale 1ns/1ps
`include "wdmc_defines.svh"

module wdmc_ctrl_test
  import wdmc_pkg::*;
();
  logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic           user_row_valid, early_warn_event, timeout_event;
  logic           counter_run, wdt_reset, irq;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    haddr, hwdata, hrdata, rd_data;
  logic [3:0]     timeout_period_sel, window_period, early_warn_offset;
  wdmc_user_row_t user_row;
  wdmc_mode_t     mode;
  int             bad_count, cmp_count;
  // Model state
  bit             m_en, m_wen, m_lock;
  bit [3:0]       m_per, m_win, m_ewo;
  bit [2:0]       m_mask, m_flag;

  wdmc_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .user_row_valid, .user_row,
    .early_warn_event, .timeout_event, .counter_run, .mode, .timeout_period_sel,
    .window_period, .early_warn_offset, .wdt_reset, .irq);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Looks at hready mid-cycle so the edge that samples it is never raced
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 200) begin
        bad_count++;
        $display("CHECK FAILED hreadyout expected 1 seen %b", hreadyout);
        give_verdict();
      end
      @(negedge hclk);
    end
    rd_data = hrdata;
    @(posedge hclk);
  endtask

  function automatic logic [2:0] m_mode();
    if (!m_en)
      return 3'h0;
    return 3'(1 + 2 * m_wen + m_mask[0]);
  endfunction

  function automatic logic [31:0] m_reg(logic [7:0] a);
    case (a)
      `WDMC_OFS_CONTROL_A_REG:   return {24'h0, m_lock, 4'h0, m_wen, m_en, 1'b0};
      `WDMC_OFS_CONFIG:  return {24'h0, m_win, m_per};
      `WDMC_OFS_EARLY_WARN_CTRL_REG:  return {28'h0, m_ewo};
      `WDMC_OFS_INTMASK: return {29'h0, m_mask};
      `WDMC_OFS_INTFLAG: return {29'h0, m_flag};
      `WDMC_OFS_MODE:    return {27'h0, m_en, 1'b0, m_mode()};
      default:           return 32'h0;
    endcase
  endfunction

  function automatic void m_write(logic [7:0] a, logic [31:0] d);
    case (a)
      `WDMC_OFS_CONTROL_A_REG: begin
        if (!m_en) begin
          {m_lock, m_wen, m_en} = {d[7], d[2], d[1]};
        end else begin
          if (d[2] != m_wen || d[7] != m_lock)
            m_flag[1] = 1'b1;
          if (!d[1] && m_lock)
            m_flag[2] = 1'b1;
          else if (!d[1])
            m_en = 1'b0;
        end
      end
      `WDMC_OFS_CONFIG: begin
        if (m_en)
          m_flag[1] = 1'b1;
        else
          {m_win, m_per} = d[7:0];
      end
      `WDMC_OFS_EARLY_WARN_CTRL_REG: begin
        if (m_en)
          m_flag[1] = 1'b1;
        else
          m_ewo = d[3:0];
      end
      `WDMC_OFS_INTMASK: m_mask = d[2:0];
      `WDMC_OFS_INTFLAG: m_flag = m_flag & ~d[2:0];
      default: ;
    endcase
  endfunction

  task automatic bus(bit wr, logic [7:0] a, logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    if (wr)
      m_write(a, d);
  endtask

  task automatic check_all();
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    cmp("mode", {29'h0, m_mode()}, {29'h0, mode}); // decode
    cmp("counter_run", {31'h0, m_en}, {31'h0, counter_run}); // stopped
    cmp("timeout_period_sel", {28'h0, m_per}, {28'h0, timeout_period_sel}); // period
    cmp("window_period", {28'h0, m_win}, {28'h0, window_period}); // window
    cmp("early_warn_offset", {28'h0, m_ewo}, {28'h0, early_warn_offset}); // offset
    cmp("irq", {31'h0, |(m_flag & m_mask)}, {31'h0, irq}); // level irq
    cmp("hresp", 32'h0, {31'h0, hresp}); // always okay
    @(posedge hclk);
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 8'(a), 32'h0); // read
      cmp("register", m_reg(8'(a)), rd_data); // readback
    end
  endtask

  task automatic events(bit ew, bit to);
    int n;
    early_warn_event <= ew;
    timeout_event    <= to;
    @(posedge hclk);
    early_warn_event <= 1'b0;
    timeout_event    <= 1'b0;
    n = 0;
    repeat (4) begin
      @(negedge hclk);
      n += int'(wdt_reset === 1'b1);
    end
    @(posedge hclk);
    if (m_en && ew)
      m_flag[0] = 1'b1;
    cmp("wdt_reset pulses", 32'(to & m_en), 32'(n)); // no reset when stopped
  endtask

  // Bus read is issued early on purpose: it must stall until the row lands
  task automatic do_reset(wdmc_user_row_t row);
    hresetn        <= 1'b0;
    user_row_valid <= 1'b0;
    user_row       <= row;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    fork
      bus(1'b0, `WDMC_OFS_CONTROL_A_REG, 32'h0); // early read stalls
      begin
        repeat (12) @(posedge hclk);
        user_row_valid <= 1'b1;
      end
    join
    {m_lock, m_wen, m_en} = row.ctrl;
    {m_win, m_per} = row.cfg;
    m_ewo = row.early_warn_offset;
    m_mask = 3'h0;
    m_flag = 3'h0;
    cmp("ctrl after load", m_reg(`WDMC_OFS_CONTROL_A_REG), rd_data); // row load
    check_all(); // row load
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    user_row_valid = 1'b0;
    user_row = '0;
    early_warn_event = 1'b0;
    timeout_event = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'h4940));
    for (int r = 0; r < 4; r++) begin
      do_reset(wdmc_user_row_t'(15'($urandom))); // random row
      for (int i = 0; i < 24; i++) begin
        bus(1'b1, 8'($urandom_range(7, 0) * 4), $urandom); // protection
        events(1'($urandom), 1'($urandom)); // events
        if (i % 6 == 5)
          check_all(); // state
      end
      $display("test random_%0d done", r);
    end
    do_reset('0);
    bus(1'b1, `WDMC_OFS_CONFIG, 32'h5a); // period and window before enable
    bus(1'b1, `WDMC_OFS_EARLY_WARN_CTRL_REG, 32'h3); // setup
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `WDMC_OFS_INTMASK, 32'(m[0])); // warn enable
      bus(1'b1, `WDMC_OFS_CONTROL_A_REG, {29'h0, m[1], 2'b10}); // wen with enable
      check_all(); // mode table
      events(1'b1, 1'b1); // running
      bus(1'b1, `WDMC_OFS_CONFIG, 32'ha5); // refused
      bus(1'b1, `WDMC_OFS_CONTROL_A_REG, {29'h0, !m[1], 2'b00}); // wen with disable
      check_all(); // stopped
      events(1'b1, 1'b1); // stopped
    end
    $display("test mode_table done");
    bus(1'b1, `WDMC_OFS_INTMASK, 32'h7); // unmask
    bus(1'b1, `WDMC_OFS_CONTROL_A_REG, 32'h82); // lock with enable
    bus(1'b1, `WDMC_OFS_CONTROL_A_REG, 32'h0); // disable refused
    check_all(); // still enabled
    bus(1'b1, `WDMC_OFS_INTMASK, 32'h1); // mask
    check_all(); // masked
    bus(1'b1, `WDMC_OFS_INTFLAG, 32'h7); // clear
    check_all(); // cleared
    $display("test lock done");
    give_verdict();
  end
endmodule
